// >>> core/gpio_port_pin_options.sv
/*
 * Pin-option logic for one 8-bit port: crystal override, alternate
 * function selection, open-drain, high drive and stop-mode wake.
 * Assumes the CPU strobes are one cycle wide, pin inputs are
 * synchronous to clk_sys, and clk_sys runs during STOP.
 */
`timescale 1ns/10ps
module gpio_port_pin_options #(
    parameter bit PORT_IS_A = 1'b0  // 1: crystal port, 0: analog port
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // CPU access
    input wire gpio_opt_pkg::cpu_req_t cpu_req,
    output logic [7:0] ctl_rdata,
    // Chip state
    input wire logic crystal_enable,
    input wire logic pkg_28pin,
    input wire logic stop_mode,
    // Port data and peripheral sources
    input wire logic [7:0] port_dout,
    input wire logic [7:0] port_drive,
    input wire logic [7:0] alt_dout,
    input wire logic [7:0] alt_drive,
    // Pin pads
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_n,
    output logic [7:0] pin_high_drive,
    // Function routing
    output logic [7:0] analog_sel,
    output logic ext_clock_sel,
    output logic wake_req
);
    import gpio_opt_pkg::*;

    // ************************************************
    // Index register
    // ************************************************
    logic [7:0] index_r;    // Sub-register index
    logic [7:0] index_nxt;

    // Index written directly, held across accesses
    always_comb begin
        index_nxt = index_r;
        if (cpu_req.addr_wr) begin
            index_nxt = cpu_req.wdata;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            index_r <= RST_INDEX;
        end else begin
            index_r <= index_nxt;
        end
    end

    // ************************************************
    // Sub-registers
    // ************************************************
    pin_cfg_t cfg;          // Registered configuration

    // Index must already hold the target before the access
    sub_reg_file u_regs (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr_en(cpu_req.ctl_wr),
        .rd_en(cpu_req.ctl_rd),
        .idx(index_r),
        .wdata(cpu_req.wdata),
        .cfg(cfg),
        .rdata(ctl_rdata)
    );

    // ************************************************
    // Per-pin option logic
    // ************************************************
    logic [7:0] xtal_hold;  // Pin taken by the crystal
    logic [7:0] analog_on;  // Analog function connected
    logic [7:0] src_val;    // Chosen output value
    logic [7:0] drive_on;   // Digital driver wanted
    logic external_clock_input_function_on;         // External clock function live

    // Clock input only when enabled and select bit is 0
    assign external_clock_input_function_on = !PORT_IS_A && cfg.alt_enable_bits[PIN_EXT_CLOCK] &&
                      !cfg.alt_select_first[PIN_EXT_CLOCK];

    genvar n;
    generate
        for (n = 0; n < 8; n++) begin : g_pin
            // Crystal overrides every other setting except the wake enable
            if (PORT_IS_A && (n == PIN_CRYSTAL_IN ||
                              n == PIN_CRYSTAL_OUT)) begin : g_xtal
                assign xtal_hold[n] = crystal_enable;
            end else begin : g_plain
                assign xtal_hold[n] = 1'b0;
            end
            // Analog select; second select set plays no part
            if (PORT_IS_A || n > PIN_LAST_ANALOG) begin : g_no_ana
                assign analog_on[n] = 1'b0;
            end else if (n == PIN_REFERENCE) begin : g_ref
                assign analog_on[n] = cfg.alt_enable_bits[n] &&
                    cfg.alt_select_first[n] && pkg_28pin;
            end else begin : g_ana
                assign analog_on[n] = cfg.alt_enable_bits[n] &&
                    cfg.alt_select_first[n];
            end
            // Digital source: peripheral only on the crystal port
            if (PORT_IS_A) begin : g_src_a
                assign src_val[n] = cfg.alt_enable_bits[n] ?
                                    alt_dout[n] : port_dout[n];
                assign drive_on[n] = cfg.alt_enable_bits[n] ?
                                     alt_drive[n] : port_drive[n];
            end else begin : g_src_b
                // Analog port functions are inputs, so port data drives
                assign src_val[n] = port_dout[n];
                assign drive_on[n] = port_drive[n];
            end
        end
    endgenerate

    // ************************************************
    // Pad outputs
    // ************************************************
    logic [7:0] pin_out_r;
    logic [7:0] pin_out_nxt;
    logic [7:0] pin_oe_n_r;
    logic [7:0] pin_oe_n_nxt;
    logic [7:0] pin_hd_r;
    logic [7:0] pin_hd_nxt;
    logic [7:0] analog_sel_r;
    logic [7:0] analog_sel_nxt;
    logic ext_clock_sel_r;
    logic ext_clock_sel_nxt;
    logic [7:0] driver_off;

    // Driver off for crystal, analog and clock-input pins
    always_comb begin
        driver_off = xtal_hold | analog_on | ~drive_on;
        driver_off[PIN_EXT_CLOCK] = driver_off[PIN_EXT_CLOCK] | external_clock_input_function_on;
        // Open drain: a high is released, never driven
        pin_out_nxt = src_val & ~cfg.open_drain_bits;
        pin_oe_n_nxt = driver_off |
                       (cfg.open_drain_bits & src_val);
        // Strength follows its bit whatever feeds the driver; only the crystal clears it
        pin_hd_nxt = cfg.high_drive_bits & ~xtal_hold;
        analog_sel_nxt = analog_on;
        ext_clock_sel_nxt = external_clock_input_function_on;
    end

    // Registers only; pads released under reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_out_r <= 8'h00;
            pin_oe_n_r <= 8'hff;
            pin_hd_r <= 8'h00;
            analog_sel_r <= 8'h00;
            ext_clock_sel_r <= 1'b0;
        end else begin
            pin_out_r <= pin_out_nxt;
            pin_oe_n_r <= pin_oe_n_nxt;
            pin_hd_r <= pin_hd_nxt;
            analog_sel_r <= analog_sel_nxt;
            ext_clock_sel_r <= ext_clock_sel_nxt;
        end
    end

    assign pin_out = pin_out_r;
    assign pin_oe_n = pin_oe_n_r;
    assign pin_high_drive = pin_hd_r;
    assign analog_sel = analog_sel_r;
    assign ext_clock_sel = ext_clock_sel_r;

    // ************************************************
    // Stop-mode wake
    // ************************************************
    // Sampled on clk_sys; a glitch shorter than a cycle can be missed
    wake_detect u_wake (
        .clk_sys(clk_sys),
        .rst(rst),
        .stop_mode(stop_mode),
        .pin_in(pin_in),
        .enable(cfg.wake_source_bits),
        .wake_req(wake_req)
    );

    // ************************************************
    // Checks
    // ************************************************
    logic [7:0] pin_last_r;  // Previous pin sample
    logic sent_r;            // Request already given this STOP
    logic edge_any;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_last_r <= 8'h00;
            sent_r <= 1'b0;
        end else begin
            pin_last_r <= pin_in;
            sent_r <= wake_req ? 1'b1 : (stop_mode ? sent_r : 1'b0);
        end
    end

    assign edge_any = |((pin_in ^ pin_last_r) & cfg.wake_source_bits);

    // The helper above keeps its own copy of the wake bookkeeping, so a
    // slip in the detector cannot hide behind the logic that made it;
    // a request may leave STOP at once, so nothing waits on stop_mode
    AST_XTAL_OVERRIDE: assert property (
        @(posedge clk_sys) disable iff (rst)
        (PORT_IS_A && crystal_enable) |=> (pin_oe_n[1:0] == 2'b11))
        else $error("crystal pins still driven");

    AST_XTAL_WEAK: assert property (
        @(posedge clk_sys) disable iff (rst)
        (PORT_IS_A && crystal_enable) |=> (pin_high_drive[1:0] == 2'b00))
        else $error("crystal pins left on high drive");

    AST_EXTERNAL_CLOCK_INPUT_FUNCTION_SEL: assert property (
        @(posedge clk_sys) disable iff (rst)
        ext_clock_sel |-> (!PORT_IS_A && !$past(cfg.alt_select_first[3])
                           && $past(cfg.alt_enable_bits[3])))
        else $error("clock input chosen without its selection");

    AST_EXTERNAL_CLOCK_INPUT_FUNCTION_PIN_OFF: assert property (
        @(posedge clk_sys) disable iff (rst)
        ext_clock_sel |-> pin_oe_n[PIN_EXT_CLOCK])
        else $error("clock input pin still driven");

    AST_ANALOG_PIN_OFF: assert property (
        @(posedge clk_sys) disable iff (rst)
        (analog_sel & ~pin_oe_n) == 8'h00)
        else $error("analog pin still driven");

    AST_ALT_ENABLE_NEEDED: assert property (
        @(posedge clk_sys) disable iff (rst)
        (analog_sel & ~$past(cfg.alt_enable_bits)) == 8'h00)
        else $error("analog function without alternate enable");

    AST_REF_PACKAGE: assert property (
        @(posedge clk_sys) disable iff (rst)
        analog_sel[PIN_REFERENCE] |-> $past(pkg_28pin))
        else $error("reference function on small package");

    AST_OPEN_DRAIN: assert property (
        @(posedge clk_sys) disable iff (rst)
        ##1 ((pin_out & $past(cfg.open_drain_bits)) == 8'h00))
        else $error("open-drain pin drives high");

    AST_HIGH_DRIVE_WRITE: assert property (
        @(posedge clk_sys) disable iff (rst)
        (cpu_req.ctl_wr && index_r == IDX_HIGH_DRIVE) |=>
        (cfg.high_drive_bits == $past(cpu_req.wdata)) ##1
        (pin_high_drive == ($past(cfg.high_drive_bits) &
                            ~$past(xtal_hold))))
        else $error("high-drive write not applied");

    AST_HIGH_DRIVE_PIN: assert property (
        @(posedge clk_sys) disable iff (rst)
        ##1 (pin_high_drive == ($past(cfg.high_drive_bits) &
                                ~$past(xtal_hold))))
        else $error("drive strength not following its bits");

    AST_WAKE_WRITE: assert property (
        @(posedge clk_sys) disable iff (rst)
        (cpu_req.ctl_wr && index_r == IDX_WAKE_ENABLE) |=>
        (cfg.wake_source_bits == $past(cpu_req.wdata)))
        else $error("wake enable write not applied");

    AST_WAKE_FIRES: assert property (
        @(posedge clk_sys) disable iff (rst)
        ($past(stop_mode) && stop_mode && edge_any && !sent_r &&
         !wake_req) |=> wake_req)
        else $error("enabled transition did not wake");

    AST_WAKE_ONLY_STOP: assert property (
        @(posedge clk_sys) disable iff (rst)
        !stop_mode |=> !wake_req)
        else $error("wake request outside stop mode");

    AST_WAKE_CAUSE: assert property (
        @(posedge clk_sys) disable iff (rst)
        wake_req |-> ($past(edge_any) && $past(stop_mode)))
        else $error("wake request without enabled transition");

    AST_WAKE_SINGLE: assert property (
        @(posedge clk_sys) disable iff (rst)
        sent_r |-> !wake_req)
        else $error("second wake request in one stop period");

    COV_WAKE: cover property (@(posedge clk_sys) disable iff (rst)
        stop_mode ##1 wake_req);
    COV_XTAL: cover property (@(posedge clk_sys) disable iff (rst)
        crystal_enable ##1 (pin_oe_n[0] && pin_oe_n[1]));
    COV_ANALOG: cover property (@(posedge clk_sys) disable iff (rst)
        analog_sel[3]);
    COV_OPEN_DRAIN: cover property (@(posedge clk_sys) disable iff (rst)
        (cfg.open_drain_bits[0] && drive_on[0]) ##1 pin_oe_n[0]);
    COV_EXTERNAL_CLOCK_INPUT_FUNCTION: cover property (@(posedge clk_sys) disable iff (rst)
        ext_clock_sel);

endmodule : gpio_port_pin_options

// >>> core/gpio_opt_pkg.sv
/*
 * Shared constants and types for the port pin-option logic: sub-register
 * indices, reset values, pin positions, the configuration carrier and
 * the wake detector states.
 * Assumes one 8-bit port reached through an index register and a
 * control register, clocked by clk_sys.
 */
package gpio_opt_pkg;

    // ************************************************
    // Sub-register indices
    // ************************************************
    localparam logic [7:0] IDX_ALT_ENABLE = 8'h02;  // Alternate enable
    localparam logic [7:0] IDX_OPEN_DRAIN = 8'h03;  // Open-drain control
    localparam logic [7:0] IDX_HIGH_DRIVE = 8'h04;  // High-drive enable
    localparam logic [7:0] IDX_WAKE_ENABLE = 8'h05; // Wake source enable
    localparam logic [7:0] IDX_ALT_SEL1 = 8'h07;    // First select set
    localparam logic [7:0] IDX_ALT_SEL2 = 8'h08;    // Second select set

    // ************************************************
    // Reset values
    // ************************************************
    localparam logic [7:0] RST_ALT_ENABLE = 8'h00;
    localparam logic [7:0] RST_OPEN_DRAIN = 8'h00;
    localparam logic [7:0] RST_HIGH_DRIVE = 8'h00;
    localparam logic [7:0] RST_WAKE_ENABLE = 8'h00;
    localparam logic [7:0] RST_ALT_SEL1 = 8'h00;
    localparam logic [7:0] RST_ALT_SEL2 = 8'h00;
    localparam logic [7:0] RST_INDEX = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

    // ************************************************
    // Pin positions
    // ************************************************
    localparam int PIN_CRYSTAL_IN = 0;   // crystal_pin_in
    localparam int PIN_CRYSTAL_OUT = 1;  // crystal_pin_out
    localparam int PIN_EXT_CLOCK = 3;    // ext_clock_pin
    localparam int PIN_REFERENCE = 5;    // reference_capable_pin
    localparam int PIN_LAST_ANALOG = 5;  // Pins above carry reserved only

    // ************************************************
    // Carriers
    // ************************************************
    typedef struct packed {
        logic [7:0] alt_select_second;
        logic [7:0] alt_select_first;
        logic [7:0] wake_source_bits;
        logic [7:0] high_drive_bits;
        logic [7:0] open_drain_bits;
        logic [7:0] alt_enable_bits;
    } pin_cfg_t;

    typedef struct packed {
        logic addr_wr;      // Write the index register
        logic ctl_wr;       // Write the indexed sub-register
        logic ctl_rd;       // Read the indexed sub-register
        logic [7:0] wdata;  // Write data
    } cpu_req_t;

    typedef enum logic [1:0] {
        WAKE_IDLE = 2'b00,
        WAKE_ARMED = 2'b01,
        WAKE_SENT = 2'b10
    } wake_state_t;

endpackage : gpio_opt_pkg

// >>> core/sub_reg_file.sv
/*
 * Indexed sub-register store for the port pin options, with a
 * registered read port.
 * Assumes the caller supplies the index and one-cycle strobes.
 */
`timescale 1ns/10ps
module sub_reg_file (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Access
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] idx,
    input wire logic [7:0] wdata,
    // Results
    output gpio_opt_pkg::pin_cfg_t cfg,
    output logic [7:0] rdata
);
    import gpio_opt_pkg::*;

    pin_cfg_t cfg_r;    // Stored sub-registers
    pin_cfg_t cfg_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    // ************************************************
    // Write and read decode
    // ************************************************
    always_comb begin
        cfg_nxt = cfg_r;
        rdata_nxt = rdata_r;
        // Unknown indices drop the write
        if (wr_en) begin
            unique case (idx)
                IDX_ALT_ENABLE: cfg_nxt.alt_enable_bits = wdata;
                IDX_OPEN_DRAIN: cfg_nxt.open_drain_bits = wdata;
                IDX_HIGH_DRIVE: cfg_nxt.high_drive_bits = wdata;
                IDX_WAKE_ENABLE: cfg_nxt.wake_source_bits = wdata;
                IDX_ALT_SEL1: cfg_nxt.alt_select_first = wdata;
                IDX_ALT_SEL2: cfg_nxt.alt_select_second = wdata;
                default: cfg_nxt = cfg_r;
            endcase
        end
        // Read data held until the next read
        if (rd_en) begin
            unique case (idx)
                IDX_ALT_ENABLE: rdata_nxt = cfg_r.alt_enable_bits;
                IDX_OPEN_DRAIN: rdata_nxt = cfg_r.open_drain_bits;
                IDX_HIGH_DRIVE: rdata_nxt = cfg_r.high_drive_bits;
                IDX_WAKE_ENABLE: rdata_nxt = cfg_r.wake_source_bits;
                IDX_ALT_SEL1: rdata_nxt = cfg_r.alt_select_first;
                IDX_ALT_SEL2: rdata_nxt = cfg_r.alt_select_second;
                default: rdata_nxt = RDATA_UNMAPPED;
            endcase
        end
    end

    // Registers only
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfg_r <= {RST_ALT_SEL2, RST_ALT_SEL1, RST_WAKE_ENABLE,
                      RST_HIGH_DRIVE, RST_OPEN_DRAIN, RST_ALT_ENABLE};
            rdata_r <= RDATA_UNMAPPED;
        end else begin
            cfg_r <= cfg_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign cfg = cfg_r;
    assign rdata = rdata_r;

endmodule : sub_reg_file

// >>> core/wake_detect.sv
/*
 * Stop-mode wake detector: one recovery pulse per STOP period on any
 * transition of an enabled pin.
 * Assumes clk_sys keeps running during STOP and pins are synchronous.
 */
`timescale 1ns/10ps
module wake_detect (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Inputs
    input wire logic stop_mode,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] enable,
    // Request
    output logic wake_req
);
    import gpio_opt_pkg::*;

    wake_state_t state_r;
    wake_state_t state_nxt;
    logic [7:0] prev_r;     // Last pin sample
    logic req_r;
    logic req_nxt;
    logic edge_any;

    // Either direction counts, gated per pin
    assign edge_any = |((pin_in ^ prev_r) & enable);

    // ************************************************
    // Request state machine
    // ************************************************
    always_comb begin
        state_nxt = state_r;
        req_nxt = 1'b0;
        unique case (state_r)
            WAKE_IDLE: begin
                if (stop_mode) begin
                    state_nxt = WAKE_ARMED;
                end
            end
            WAKE_ARMED: begin
                if (!stop_mode) begin
                    state_nxt = WAKE_IDLE;
                end else if (edge_any) begin
                    // Single request per STOP period
                    state_nxt = WAKE_SENT;
                    req_nxt = 1'b1;
                end
            end
            WAKE_SENT: begin
                if (!stop_mode) begin
                    state_nxt = WAKE_IDLE;
                end
            end
            default: state_nxt = WAKE_IDLE;
        endcase
    end

    // Registers only
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_r <= WAKE_IDLE;
            prev_r <= 8'h00;
            req_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            prev_r <= pin_in;
            req_r <= req_nxt;
        end
    end

    assign wake_req = req_r;

endmodule : wake_detect

// >>> verification/pad_model.sv
/*
 * Pad model for the far side of one port: resolves each pin level.
 * Assumes an active-low port enable and outside sources set by the bench.
 */
`timescale 1ns/10ps
module pad_model (
    // Port side
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    // Outside sources
    input wire logic [7:0] ext_level,
    input wire logic [7:0] ext_en,
    // Resolved pad levels
    output logic [7:0] pin_in
);
    // ********************************
    // Pin resolution
    // ********************************
    // Port wins where it drives; an idle pad floats up on its pull-up,
    // so a released pin never keeps its last driven value
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_level[i];
            end else begin
                pin_in[i] = 1'b1;
            end
        end
    end
endmodule : pad_model

// >>> verification/tb_gpio_port_pin_options.sv
/*
 * Self-checking bench: random pin options on a port B and a port A
 * instance sharing one CPU bus, plus stop-mode wake checks.
 * Assumes the package and design files are compiled first.
 */
`timescale 1ns/10ps
module tb_gpio_port_pin_options;
    import gpio_opt_pkg::*;
    // ********************************
    // Signals
    // ********************************
    logic clk_sys, rst, xtal, pkg28, stop;
    cpu_req_t req;
    logic [7:0] rdata, pdout, pdrv, adout, adrv, ext_lv, ext_en;
    logic [7:0] pin_in, pin_out, oe_n, hd, ana, oe_a, hd_a, wcnt;
    logic extc, wake;
    int err_count, num_checks;
    // ********************************
    // Instances
    // ********************************
    gpio_port_pin_options #(.PORT_IS_A(1'b0)) DUT (.clk_sys(clk_sys),
        .rst(rst), .cpu_req(req), .ctl_rdata(rdata),
        .crystal_enable(xtal), .pkg_28pin(pkg28), .stop_mode(stop),
        .port_dout(pdout), .port_drive(pdrv), .alt_dout(adout),
        .alt_drive(adrv), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(oe_n), .pin_high_drive(hd), .analog_sel(ana),
        .ext_clock_sel(extc), .wake_req(wake));
    gpio_port_pin_options #(.PORT_IS_A(1'b1)) DUT_A (.clk_sys(clk_sys),
        .rst(rst), .cpu_req(req), .ctl_rdata(),
        .crystal_enable(xtal), .pkg_28pin(pkg28), .stop_mode(stop),
        .port_dout(pdout), .port_drive(pdrv), .alt_dout(adout),
        .alt_drive(adrv), .pin_in(pin_in), .pin_out(),
        .pin_oe_n(oe_a), .pin_high_drive(hd_a), .analog_sel(),
        .ext_clock_sel(), .wake_req());
    pad_model PADS (.pin_out(pin_out), .pin_oe_n(oe_n),
        .ext_level(ext_lv), .ext_en(ext_en), .pin_in(pin_in));
    // ********************************
    // Clock, wake counter, watchdog
    // ********************************
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // Counts recovery pulses; the sequence compares differences, so
    // this process stays the only writer of the count
    always @(posedge clk_sys) begin
        if (rst) begin
            wcnt <= 8'h00;
        end else if (wake === 1'b1) begin
            wcnt <= wcnt + 8'h01;
        end
    end
    // Run needs about 570 cycles; allow far more before giving up
    initial begin
        #(25 * 20000);
        err_count++;
        tally_and_finish();
    end
    // ********************************
    // Tasks and expectations
    // ********************************
    task chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Index first, then the sub-register, as the port expects
    task wr_reg(input logic [7:0] idx, input logic [7:0] d);
        @(negedge clk_sys) req = '{1'b1, 1'b0, 1'b0, idx};
        @(negedge clk_sys) req = '{1'b0, 1'b1, 1'b0, d};
        @(negedge clk_sys) req = '0;
    endtask : wr_reg
    task rd_reg(input logic [7:0] idx, input logic [7:0] exp);
        @(negedge clk_sys) req = '{1'b1, 1'b0, 1'b0, idx};
        @(negedge clk_sys) req = '{1'b0, 1'b0, 1'b1, 8'h00};
        @(negedge clk_sys) req = '0;
        chk(rdata, exp);
    endtask : rd_reg
    // Analog routing: pins 0..5 only, pin 5 needs the large package
    function automatic logic [7:0] exp_ana(input logic [7:0] en,
        input logic [7:0] s1, input logic p28);
        logic [7:0] m;
        m = en & s1 & 8'h3f;
        if (!p28) m[5] = 1'b0;
        return m;
    endfunction : exp_ana
    task tally_and_finish();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish
    // ********************************
    // Main sequence
    // ********************************
    initial begin
        logic [7:0] en, od, hdv, s1, a, drv, act, w0, sa, da;
        logic xc;
        int seed;
        rst = 1'b1;
        req = '0;
        {xtal, pkg28, stop} = 3'b000;
        {pdout, pdrv, adout, adrv} = 32'h0;
        ext_lv = 8'h00;
        ext_en = 8'hff;
        err_count = 0;
        num_checks = 0;
        seed = $urandom(84);
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys) rst = 1'b0;
        rd_reg(IDX_HIGH_DRIVE, 8'h00);
        rd_reg(IDX_WAKE_ENABLE, 8'h00);
        wr_reg(8'h09, 8'h5a);
        rd_reg(8'h09, RDATA_UNMAPPED);
        for (int k = 0; k < 24; k++) begin
            {en, od, hdv, s1} = $urandom;
            // Corners: every analog select, clock input alone, pin 5 alone
            if (k == 0) {en, s1, od} = 24'hffff00;
            if (k == 1) {en, s1} = 16'h0800;
            if (k == 2) {en, s1} = 16'h2020;
            wr_reg(IDX_ALT_ENABLE, en);
            wr_reg(IDX_OPEN_DRAIN, od);
            wr_reg(IDX_HIGH_DRIVE, hdv);
            wr_reg(IDX_ALT_SEL1, s1);
            wr_reg(IDX_ALT_SEL2, 8'($urandom));
            {pdout, pdrv, adout, adrv} = $urandom;
            {xtal, pkg28} = 2'($urandom);
            // Reference pin: small package first, then large
            if (k == 0 || k == 2) pkg28 = (k == 2);
            ext_en = ~pdrv;
            ext_lv = 8'($urandom);
            repeat (3) @(negedge clk_sys);
            a = exp_ana(en, s1, pkg28);
            xc = en[3] & ~s1[3];
            drv = pdrv & ~a & ~{4'h0, xc, 3'h0};
            act = drv & (~od | ~pdout);
            chk(ana, a);
            chk({7'h0, extc}, {7'h0, xc});
            chk(oe_n, ~act);
            chk(pin_out & act, pdout & ~od & act);
            chk(hd, hdv);
            chk(hd_a, hdv & (xtal ? 8'hfc : 8'hff));
            if (xtal) chk({6'h0, oe_a[1:0]}, 8'h03);
            // Crystal port: alternate enable hands the pin to the peripheral
            sa = (en & adout) | (~en & pdout);
            da = ((en & adrv) | (~en & pdrv)) & ~{6'h0, xtal, xtal};
            chk(oe_a, ~(da & ~(od & sa)));
            rd_reg(IDX_HIGH_DRIVE, hdv);
        end
        // Wake: pin 2 enabled, pin 0 not; outside sources drive all pins
        wr_reg(IDX_WAKE_ENABLE, 8'h04);
        rd_reg(IDX_WAKE_ENABLE, 8'h04);
        pdrv = 8'h00;
        ext_en = 8'hff;
        ext_lv = 8'h00;
        // Pin 2 rises then falls in the first stop period, falls then rises in the second
        for (int p = 0; p < 2; p++) begin
            repeat (3) @(negedge clk_sys);
            w0 = wcnt;
            stop = 1'b1;
            repeat (3) @(negedge clk_sys);
            ext_lv = ext_lv ^ 8'h01;
            repeat (4) @(negedge clk_sys);
            chk(wcnt - w0, 8'h00);
            ext_lv = ext_lv ^ 8'h04;
            repeat (3) @(negedge clk_sys);
            ext_lv = ext_lv ^ 8'h04;
            repeat (4) @(negedge clk_sys);
            chk(wcnt - w0, 8'h01);
            stop = 1'b0;
            ext_lv = 8'h04;
        end
        // Mid-run reset returns the wake and high-drive sub-registers to their reset values
        @(negedge clk_sys) rst = 1'b1;
        @(negedge clk_sys) rst = 1'b0;
        rd_reg(IDX_WAKE_ENABLE, RST_WAKE_ENABLE);
        rd_reg(IDX_HIGH_DRIVE, RST_HIGH_DRIVE);
        chk(hd, RST_HIGH_DRIVE);
        tally_and_finish();
    end
endmodule : tb_gpio_port_pin_options
